//--- logic/pagm_pkg.sv
`default_nettype none
package pagm_pkg;
    // ------------------------------------------------------------
    // configuration constants and bit positions of the misc control word
    // ------------------------------------------------------------
    localparam int unsigned PAGM_MISC_WIDTH   = 16;
    localparam int unsigned PAGM_PARK_BIT     = 8;
    localparam int unsigned PAGM_EXT_ARB_BIT  = 9;
    localparam int unsigned PAGM_MASTERS      = 4;
    localparam logic [3:0]  PAGM_LINES_IDLE   = 4'hf;
    localparam logic [1:0]  PAGM_OWNER_RESET  = 2'h0;

    typedef enum logic [2:0] {
        PAGM_IDLE  = 3'h1,
        PAGM_GRANT = 3'h2,
        PAGM_PARK  = 3'h4
    } pagm_state_type;
endpackage
`default_nettype wire

//--- logic/pagm_arbiter.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// R1 - internal mode drives all four grant lines
// R2 - external mode: grant 0 is an input
// R3 - external mode: grants 3..1 stay outputs
// R4 - control bit 9 selects arbiter mode
// R5 - control bit 8 parks on last master
// R6 - current master asserts initiator ready low
// R7 - exclusive master asserts open-drain lock line
// R8 - external mode: request 0 output, 3..1 inputs
// R9 - external masters request on own lines
// R10 - at most one grant asserted at once
module pagm_arbiter
    import pagm_pkg::*;
(
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       clk_en,
    input  wire logic [PAGM_MISC_WIDTH-1:0] misc_ctrl,
    input  wire logic [3:0]                 bus_request_lines_b,
    input  wire logic [3:0]                 bus_grant_lines_in_b,
    output logic      [3:0]                 bus_grant_lines_b,
    output logic      [3:0]                 bus_grant_lines_oe,
    output logic                            bus_request_line0_b,
    output logic                            bus_request_line0_oe,
    input  wire logic                       own_bus_want,
    input  wire logic                       own_data_ready,
    input  wire logic                       own_lock_want,
    input  wire logic                       frame_active_b,
    input  wire logic                       initiator_ready_line_in_b,
    output logic                            initiator_ready_line_b,
    output logic                            initiator_ready_line_oe,
    output logic                            exclusive_lock_line_b,
    output logic                            exclusive_lock_line_oe,
    output logic                            own_bus_granted,
    input  wire logic [3:0]                 irq_lines_b,
    output logic      [3:0]                 irq_pending
);
    // all checks below run on the one clock and stay quiet in reset
    default clocking chk_clk @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] req_meta, req_sync, gnt_meta, gnt_sync, irq_meta, irq_sync;
    logic       frm_meta, frm_sync, irdy_meta, irdy_sync;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_meta  <= PAGM_LINES_IDLE;
            req_sync  <= PAGM_LINES_IDLE;
            gnt_meta  <= PAGM_LINES_IDLE;
            gnt_sync  <= PAGM_LINES_IDLE;
            irq_meta  <= PAGM_LINES_IDLE;
            irq_sync  <= PAGM_LINES_IDLE;
            frm_meta  <= 1'b1;
            frm_sync  <= 1'b1;
            irdy_meta <= 1'b1;
            irdy_sync <= 1'b1;
        end else if (clk_en) begin
            req_meta  <= bus_request_lines_b;
            req_sync  <= req_meta;
            gnt_meta  <= bus_grant_lines_in_b;
            gnt_sync  <= gnt_meta;
            irq_meta  <= irq_lines_b;
            irq_sync  <= irq_meta;
            frm_meta  <= frame_active_b;
            frm_sync  <= frm_meta;
            irdy_meta <= initiator_ready_line_in_b;
            irdy_sync <= irdy_meta;
        end
    end

    // ------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------
    wire ext_mode = misc_ctrl[PAGM_EXT_ARB_BIT];              // see R4
    wire park_en  = misc_ctrl[PAGM_PARK_BIT];                 // see R5
    // requests 3..1 ignored in external mode; they are pulled high
    wire [3:0] req_act = ext_mode ? 4'h0 : ~req_sync;         // see R8 R9
    // bus idle: no frame and no initiator ready seen
    wire bus_idle = frm_sync & irdy_sync;

    function automatic logic [1:0] pick(input logic [3:0] req,
                                        input logic [1:0] last);
        logic [1:0] idx;
        idx = last;
        // rotate from the master after the last owner for fairness
        for (int i = 4; i >= 1; i--) begin
            if (req[2'(int'(last) + i)]) begin
                idx = 2'(int'(last) + i);
            end
        end
        return idx;
    endfunction

    // ------------------------------------------------------------
    // internal arbiter
    // ------------------------------------------------------------
    pagm_state_type state, next_state;
    logic [1:0] owner;
    wire  [1:0] next_owner = pick(req_act, owner);
    wire        any_req    = |req_act;

    always_comb begin
        next_state = state;
        case (state)
            PAGM_IDLE: begin
                if (any_req && bus_idle) begin
                    next_state = PAGM_GRANT;
                end
            end
            PAGM_GRANT: begin
                // hold grant until owner drops request and bus is idle
                if (!req_act[owner] && bus_idle) begin
                    next_state = park_en ? PAGM_PARK : PAGM_IDLE; // see R5
                end
            end
            PAGM_PARK: begin
                if (any_req && bus_idle) begin
                    next_state = PAGM_GRANT;
                end
            end
            default: next_state = PAGM_IDLE;
        endcase
        if (ext_mode) begin
            next_state = PAGM_IDLE;
        end
    end

    wire       take    = (next_state == PAGM_GRANT) && (state != PAGM_GRANT);
    wire       grant_on = (next_state != PAGM_IDLE);
    // one-hot by construction: a single owner index decodes the line
    wire [3:0] next_gnt = grant_on ? ~(4'h1 << (take ? next_owner : owner))
                                   : PAGM_LINES_IDLE;          // see R10

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= PAGM_IDLE;
            owner <= PAGM_OWNER_RESET;
        end else if (clk_en) begin
            state <= next_state;
            if (take) begin
                owner <= next_owner;
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    wire own_gnt   = ext_mode & ~gnt_sync[0];                  // see R2
    wire own_master = own_gnt & own_bus_want;
    wire own_ready  = own_master & own_data_ready;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_grant_lines_b      <= PAGM_LINES_IDLE;
            bus_grant_lines_oe     <= PAGM_LINES_IDLE;
            bus_request_line0_b    <= 1'b1;
            bus_request_line0_oe   <= 1'b0;
            initiator_ready_line_b <= 1'b1;
            initiator_ready_line_oe <= 1'b0;
            exclusive_lock_line_b  <= 1'b1;
            exclusive_lock_line_oe <= 1'b0;
            own_bus_granted        <= 1'b0;
            irq_pending            <= 4'h0;
        end else if (clk_en) begin
            bus_grant_lines_b  <= ext_mode ? {3'h7, 1'b1} : next_gnt; // see R1
            bus_grant_lines_oe <= {3'h7, ~ext_mode};          // see R2 R3
            bus_request_line0_b  <= ~(ext_mode & own_bus_want); // see R8
            bus_request_line0_oe <= ext_mode;                 // see R8
            initiator_ready_line_b  <= ~own_ready;             // see R6
            initiator_ready_line_oe <= own_master;            // see R6
            // open drain: drive low only, else release
            exclusive_lock_line_b  <= 1'b0;
            exclusive_lock_line_oe <= own_master & own_lock_want; // see R7
            own_bus_granted        <= own_gnt;               // see R2
            irq_pending            <= ~irq_sync;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence ext_sel_s;
        misc_ctrl[PAGM_EXT_ARB_BIT] && clk_en;
    endsequence
    sequence int_sel_s;
        !misc_ctrl[PAGM_EXT_ARB_BIT] && clk_en;
    endsequence
    // owner lets go while parking is on and the arbiter is ours
    sequence park_due_s;
        state == PAGM_GRANT && next_state != PAGM_GRANT && park_en
            && !ext_mode && clk_en;
    endsequence
    sequence parked_s;
        state == PAGM_PARK && bus_grant_lines_b == ~(4'h1 << owner);
    endsequence
    sequence own_ready_s;
        own_ready && clk_en;
    endsequence
    sequence own_lock_s;
        own_master && own_lock_want && clk_en;
    endsequence

    grant_onehot_a: assert property (                          // see R10
        $onehot0(~bus_grant_lines_b))
        else $error("more than one grant asserted");
    int_drive_a: assert property (                             // see R1
        int_sel_s |=> bus_grant_lines_oe == 4'hf)
        else $error("grant lines not driven in internal mode");
    int_req0_a: assert property (                              // see R8
        int_sel_s |=> !bus_request_line0_oe)
        else $error("request 0 driven in internal mode");
    ext_gnt0_a: assert property (                              // see R2
        ext_sel_s |=> !bus_grant_lines_oe[0])
        else $error("grant 0 driven in external mode");
    ext_upper_a: assert property (                             // see R3 R4
        ext_sel_s |=> bus_grant_lines_oe[3:1] == 3'h7
            && bus_grant_lines_b[3:1] == 3'h7)
        else $error("upper grants not idle outputs in external mode");
    ext_req0_a: assert property (                              // see R8
        ext_sel_s |=> bus_request_line0_oe)
        else $error("request 0 not driven in external mode");
    park_hold_a: assert property (                             // see R5
        park_due_s |=> parked_s)
        else $error("bus not parked on last master");
    irdy_owner_a: assert property (                            // see R6
        !initiator_ready_line_b |-> initiator_ready_line_oe && $past(own_gnt))
        else $error("initiator ready driven without ownership");
    irdy_ready_a: assert property (                            // see R6
        own_ready_s |=> initiator_ready_line_oe && !initiator_ready_line_b)
        else $error("initiator ready not asserted by owner");
    lock_owner_a: assert property (                            // see R7
        exclusive_lock_line_oe |-> $past(own_master)
            && !exclusive_lock_line_b)
        else $error("lock driven without ownership");
    lock_want_a: assert property (                             // see R7
        own_lock_s |=> exclusive_lock_line_oe)
        else $error("lock not driven for exclusive owner");
endmodule // pagm_arbiter
`default_nettype wire

//--- bench/pagm_partner.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// far-side masters and optional outside arbiter
// ----------------------------------------------------------------
module pagm_partner (
    input  wire logic       core_clk,
    input  wire logic       ext_mode,
    input  wire logic [3:0] want,
    input  wire logic       req0_pin_b,
    output logic      [3:0] req_b,
    output logic            arb_gnt0_b
);
    initial begin
        req_b      = 4'hf;
        arb_gnt0_b = 1'b1;
    end
    // pull-ups hold the idle requests high in outside-arbiter mode
    always @(posedge core_clk) begin
        req_b      <= ext_mode ? 4'hf : ~want;
        arb_gnt0_b <= ~(ext_mode && !req0_pin_b);
    end
endmodule // pagm_partner
`default_nettype wire

//--- bench/test_pci_arbiter_grant_mode.sv
`timescale 1ns/1ps
`default_nettype none
module test_pci_arbiter_grant_mode;
    import pagm_pkg::*;
    logic                       core_clk, rst_b, o_want, o_rdy, o_lock;
    logic [PAGM_MISC_WIDTH-1:0] misc;
    logic [3:0] want, irq_b, req_b, gnt_b, gnt_oe, gnt_pin, pend, req_pin;
    logic       g0_ext, req0_b, req0_oe, irdy_b, irdy_oe, lock_b, lock_oe;
    logic       granted, frame_b;
    int         failures, cmp_count, cycles;
    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    assign gnt_pin = (gnt_oe & gnt_b) | (~gnt_oe & {3'h7, g0_ext});
    assign req_pin = {req_b[3:1], req0_oe ? req0_b : req_b[0]};
    pagm_partner i_far (.core_clk(core_clk), .ext_mode(misc[9]),
        .want(want), .req0_pin_b(req_pin[0]), .req_b(req_b),
        .arb_gnt0_b(g0_ext));
    pagm_arbiter i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
        .misc_ctrl(misc), .bus_request_lines_b(req_pin),
        .bus_grant_lines_in_b(gnt_pin), .bus_grant_lines_b(gnt_b),
        .bus_grant_lines_oe(gnt_oe), .bus_request_line0_b(req0_b),
        .bus_request_line0_oe(req0_oe), .own_bus_want(o_want),
        .own_data_ready(o_rdy), .own_lock_want(o_lock),
        .frame_active_b(frame_b),
        .initiator_ready_line_in_b(irdy_oe ? irdy_b : 1'b1),
        .initiator_ready_line_b(irdy_b), .initiator_ready_line_oe(irdy_oe),
        .exclusive_lock_line_b(lock_b), .exclusive_lock_line_oe(lock_oe),
        .own_bus_granted(granted), .irq_lines_b(irq_b), .irq_pending(pend));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [3:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_internal();
        check("oe", 4'hf, gnt_oe);
        want <= 4'h6;
        tick(5);
        check("gnt", 4'hd, gnt_b);
        want <= 4'h4;
        for (int i = 0; i < 10 && gnt_b !== 4'hb; i++) tick(1);
        check("gnt", 4'hb, gnt_b);
        want <= 4'h0;
        tick(5);
        check("gnt", 4'hf, gnt_b);
    endtask
    task automatic t_park();
        misc <= 16'h0100;
        want <= 4'h8;
        tick(5);
        want <= 4'h0;
        tick(6);
        check("park", 4'h7, gnt_b);
    endtask
    task automatic t_external();
        misc <= 16'h0200;
        o_want <= 1'b1;
        tick(2);
        check("oe", 4'he, gnt_oe);
        check("gnt", 4'hf, gnt_b | 4'h1);
        check("req0", 4'h2, {2'h0, req0_oe, req0_b});
        for (int i = 0; i < 10 && granted !== 1'b1; i++) tick(1);
        check("own", 4'h1, {3'h0, granted});
        tick(2);
        check("irdy", 4'h2, {2'h0, irdy_oe, irdy_b});
        check("lock", 4'h2, {2'h0, lock_oe, lock_b});
        o_rdy <= 1'b0;
        o_lock <= 1'b0;
        tick(2);
        check("irdy", 4'h3, {2'h0, irdy_oe, irdy_b});
        check("lock", 4'h0, {2'h0, lock_oe, lock_b});
        misc <= 16'h0000;
        o_want <= 1'b0;
        tick(2);
        check("oe", 4'hf, gnt_oe);
        check("req0", 4'h1, {2'h0, req0_oe, req0_b});
    endtask
    // a request made while a frame is on must wait for the idle bus
    task automatic t_busy();
        frame_b <= 1'b0;
        want <= 4'h1;
        tick(8);
        check("busy", 4'hf, gnt_b);
        frame_b <= 1'b1;
        for (int i = 0; i < 10 && gnt_b !== 4'he; i++) tick(1);
        check("gnt", 4'he, gnt_b);
        want <= 4'h0;
        tick(6);
        check("gnt", 4'hf, gnt_b);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // hang guard well past the fewer than a hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            end_of_test();
        end
    end
    initial begin
        {rst_b, o_want, misc, want} = '0;
        {o_rdy, o_lock} = 2'h3;
        frame_b = 1'b1;
        irq_b = 4'ha;
        tick(2);
        rst_b <= 1'b1;
        // two sync stages plus the output register before pins show
        tick(4);
        check("pend", 4'h5, pend);
        t_internal();
        t_park();
        t_external();
        t_busy();
        end_of_test();
    end
endmodule // test_pci_arbiter_grant_mode
`default_nettype wire
